// [interrupt_priority_trap_arbiter.sv]
// How it works
// - Priority in low three bits; bit three zero.
// - Level zero lowest, level seven highest.
// - Equal levels: smallest interrupt number wins.
// - Interrupt number serves directly as rank.
// - Vector equals interrupt number plus eight.
// - User level beats natural order.
// - Reset: controller idle, fetch from zero.
// - Watchdog timeout or brown-out forces reset.
// - Uninitialised pointer register use forces reset.
// - Illegal opcode resets only when executed.
// - Simultaneous trap conditions force reset.
// - Traps non-maskable, levels eight to fifteen.
// - Trap waits for current instruction to finish.
// - Invalid trap vector raises address error trap.
// - Level seven blocks interrupts, not traps.
// - Flags set regardless of enable; software clears.
// - Priority zero source never interrupts.
// - Interrupt only above current core level.
// - Nesting disable blocks interrupts during service.
//
// Implementation choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "irq_arbiter_map.svh"
module interrupt_priority_trap_arbiter
	import irq_arbiter_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [53:0] irq_event,
	input wire logic [3:0] cpu_priority_level,
	input wire logic in_service,
	input wire logic [7:0] trap_req,
	input wire logic instr_done,
	input wire logic vector_invalid,
	input wire logic watchdog_timeout,
	input wire logic brown_out_reset,
	input wire logic uninit_pointer_use,
	input wire logic illegal_opcode_fetch,
	input wire logic illegal_opcode_flushed,
	output logic irq_valid_q,
	output logic [5:0] irq_num_q,
	output logic [5:0] irq_vector_q,
	output logic [2:0] irq_level_q,
	output logic trap_take_q,
	output logic [3:0] trap_level_q,
	output logic device_reset_q,
	output logic [23:0] start_addr_q,
	output logic nesting_disable_q
);

	// ****************************************************************
	// Bus slave
	// ****************************************************************
	logic aw_held_q, w_held_q, wr_fire, rd_fire, rd_hit, wr_hit;
	logic [7:0] waddr_q;
	logic [3:0] wstrb_q;
	logic [31:0] wdata_q, wmask, rd_word;
	assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;
	assign rd_fire = s_axi_arvalid && s_axi_arready;
	assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
		{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			waddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_q <= 1'b1;
				waddr_q <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_held_q <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_held_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_held_q &&
				!(s_axi_awvalid && s_axi_awready);
			s_axi_wready <= !w_held_q && !(s_axi_wvalid && s_axi_wready);
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			s_axi_arready <= !s_axi_rvalid && !rd_fire;
			if (rd_fire) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_word;
				s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// Register file
	// ****************************************************************
	src_vec_t flag_q, flag_d, en_q, clr, rsv;
	logic [31:0] prio_wval, prio_q [`NUM_PRIO_WORDS];
	logic [`NUM_CAUSES-1:0] cause_q, cause_set;
	trap_vec_t trap_pend_q, trap_pend_d, trap_taken;
	logic wr_flag0, wr_flag1, wr_en0, wr_en1, wr_ctrl, wr_cause, wr_prio;
	logic [2:0] wr_pidx, rd_pidx;
	logic rd_prio;
	assign rsv = `RSV_MASK;
	assign wr_flag0 = wr_fire && waddr_q == `OFS_FLAG0;
	assign wr_flag1 = wr_fire && waddr_q == `OFS_FLAG1;
	assign wr_en0 = wr_fire && waddr_q == `OFS_EN0;
	assign wr_en1 = wr_fire && waddr_q == `OFS_EN1;
	assign wr_ctrl = wr_fire && waddr_q == `OFS_CTRL;
	assign wr_cause = wr_fire && waddr_q == `OFS_CAUSE;
	assign wr_prio = wr_fire && waddr_q >= `OFS_PRIO_BASE &&
		waddr_q <= `OFS_PRIO_LAST && waddr_q[1:0] == 2'h0;
	assign wr_pidx = 3'(waddr_q[4:2]);
	assign rd_prio = s_axi_araddr >= `OFS_PRIO_BASE &&
		s_axi_araddr <= `OFS_PRIO_LAST && s_axi_araddr[1:0] == 2'h0;
	assign rd_pidx = 3'(s_axi_araddr[4:2]);
	assign wr_hit = wr_flag0 || wr_flag1 || wr_en0 || wr_en1 ||
		wr_ctrl || wr_cause || wr_prio ||
		(wr_fire && waddr_q == `OFS_STAT);
	// Top bit of every nibble is dropped on write, so it reads zero.
	assign prio_wval = ((prio_q[wr_pidx] & ~wmask) | (wdata_q & wmask)) &
		{8{`PRIO_MASK}};
	// Software clears a flag by writing one; a new event in the same
	// cycle survives the clear.
	assign clr = {(wr_flag1 ? (wdata_q[`FLAG1_BITS-1:0] &
		wmask[`FLAG1_BITS-1:0]) : 22'h0),
		(wr_flag0 ? (wdata_q & wmask) : 32'h0)};
	assign flag_d = ((flag_q & ~clr) | irq_event) & ~`RSV_MASK;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flag_q <= '0;
			en_q <= '0;
			nesting_disable_q <= 1'b0;
			cause_q <= '0;
			prio_q <= '{default: 32'h0000_0000};
		end else begin
			flag_q <= flag_d;
			if (wr_en0) begin
				en_q[31:0] <= (en_q[31:0] & ~wmask) | (wdata_q & wmask);
			end
			if (wr_en1) begin
				en_q[53:32] <= 22'((en_q[53:32] & ~wmask[21:0]) |
					(wdata_q[21:0] & wmask[21:0]));
			end
			if (wr_ctrl && wstrb_q[0]) begin
				nesting_disable_q <= wdata_q[0];
			end
			if (wr_prio && wr_pidx < 3'(`NUM_PRIO_WORDS)) begin
				prio_q[wr_pidx] <= prio_wval;
			end
			cause_q <= (cause_q & ~((wr_cause && wstrb_q[0]) ?
				wdata_q[`NUM_CAUSES-1:0] : '0)) | cause_set;
		end
	end
	assign rd_hit = rd_prio || s_axi_araddr == `OFS_FLAG0 ||
		s_axi_araddr == `OFS_FLAG1 || s_axi_araddr == `OFS_EN0 ||
		s_axi_araddr == `OFS_EN1 || s_axi_araddr == `OFS_CTRL ||
		s_axi_araddr == `OFS_STAT || s_axi_araddr == `OFS_CAUSE;
	assign rd_word =
		(s_axi_araddr == `OFS_FLAG0) ? flag_q[31:0] :
		(s_axi_araddr == `OFS_FLAG1) ? {10'h000, flag_q[53:32]} :
		(s_axi_araddr == `OFS_EN0) ? en_q[31:0] :
		(s_axi_araddr == `OFS_EN1) ? {10'h000, en_q[53:32]} :
		(s_axi_araddr == `OFS_CTRL) ? {31'h0, nesting_disable_q} :
		(s_axi_araddr == `OFS_STAT) ?
		{17'h0, trap_pend_q, irq_valid_q, irq_num_q} :
		(s_axi_araddr == `OFS_CAUSE) ? {27'h0, cause_q} :
		(rd_prio && rd_pidx < 3'(`NUM_PRIO_WORDS)) ? prio_q[rd_pidx] :
		32'h0000_0000;

	// ****************************************************************
	// Interrupt arbitration
	// ****************************************************************
	src_vec_t elig;
	prio_t win_prio, src_prio [`NUM_SRC];
	logic irq_block, win_any;
	num_t win_num;
	// Trap processing, or nesting disabled while in service, blocks all.
	assign irq_block = cpu_priority_level[3] ||
		(nesting_disable_q && in_service);
	for (genvar i = 0; i < `NUM_SRC; i++) begin : g_src
		assign src_prio[i] = prio_q[i / 8][(i % 8) * 4 +: 3];
		assign elig[i] = flag_q[i] && en_q[i] && !rsv[i] && !irq_block &&
			src_prio[i] != 3'h0 &&
			{1'b0, src_prio[i]} > cpu_priority_level;
	end
	// Scanning from the top down with >= lets the lower number take a
	// tie, so the interrupt number is the natural rank itself.
	always_comb begin
		win_any = 1'b0;
		win_num = 6'h00;
		win_prio = 3'h0;
		for (int i = `NUM_SRC - 1; i >= 0; i--) begin
			if (elig[i] && (!win_any || src_prio[i] >= win_prio)) begin
				win_any = 1'b1;
				win_num = 6'(i);
				win_prio = src_prio[i];
			end
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_valid_q <= 1'b0;
			irq_num_q <= 6'h00;
			irq_vector_q <= 6'h00;
			irq_level_q <= 3'h0;
			start_addr_q <= `RESET_PC;
		end else begin
			irq_valid_q <= win_any;
			irq_num_q <= win_num;
			irq_vector_q <= 6'(win_num + `VECTOR_OFFSET);
			irq_level_q <= win_prio;
			start_addr_q <= `RESET_PC;
		end
	end

	// ****************************************************************
	// Traps and reset causes
	// ****************************************************************
	logic trap_go, lockout, illegal_exec;
	logic [2:0] trap_idx;
	assign trap_go = instr_done && trap_pend_q != 8'h00;
	always_comb begin
		trap_idx = 3'h0;
		for (int t = 0; t < `NUM_TRAPS; t++) begin
			if (trap_pend_q[t]) begin
				trap_idx = 3'(t);
			end
		end
	end
	assign trap_taken = trap_go ? (8'h01 << trap_idx) : 8'h00;
	assign trap_pend_d = (trap_pend_q & ~trap_taken) | trap_req |
		(vector_invalid ? (8'h01 << `ADDR_ERR_TRAP) : 8'h00);
	assign lockout = (trap_req & 8'(trap_req - 8'h01)) != 8'h00;
	assign illegal_exec = illegal_opcode_fetch &&
		!illegal_opcode_flushed;
	assign cause_set = {lockout, illegal_exec, uninit_pointer_use,
		brown_out_reset, watchdog_timeout};
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			trap_pend_q <= 8'h00;
			trap_take_q <= 1'b0;
			trap_level_q <= 4'h0;
			device_reset_q <= 1'b0;
		end else begin
			trap_pend_q <= trap_pend_d;
			trap_take_q <= trap_go;
			trap_level_q <= trap_go ? {1'b1, trap_idx} : 4'h0;
			device_reset_q <= cause_set != '0;
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_prio_top_zero: assert property ((src_prio[0] == prio_q[0][2:0]) &&
		(prio_q[0] & 32'h8888_8888) == 32'h0)
		else $error("priority nibble top bit set");
	a_above_level: assert property (irq_valid_q |->
		{1'b0, irq_level_q} > $past(cpu_priority_level) &&
		irq_level_q != 3'h0)
		else $error("winner not above core level");
	a_vector_plus8: assert property (irq_valid_q |->
		irq_vector_q == 6'(irq_num_q + 6'h08))
		else $error("vector does not equal number plus eight");
	a_no_reserved: assert property ((flag_q & `RSV_MASK) == '0 &&
		!(irq_valid_q && ((`RSV_MASK >> irq_num_q) & 54'h1) != 0))
		else $error("reserved source pending or chosen");
	a_nest_block: assert property (nesting_disable_q && in_service |=>
		!irq_valid_q)
		else $error("interrupt chosen while nesting disabled");
	a_trap_msb: assert property (trap_take_q |-> trap_level_q[3] &&
		$past(instr_done))
		else $error("trap taken without msb or before completion");
	a_lockout_rst: assert property (lockout |=> device_reset_q)
		else $error("simultaneous traps did not reset");
	a_flush_quiet: assert property (illegal_opcode_flushed &&
		!watchdog_timeout && !brown_out_reset && !uninit_pointer_use &&
		!lockout |=> !device_reset_q)
		else $error("flushed illegal opcode caused reset");
	a_set_wins: assert property (irq_event[0] |=> flag_q[0])
		else $error("event lost against clear");
	a_addr_err: assert property (vector_invalid |=>
		trap_pend_q[`ADDR_ERR_TRAP])
		else $error("invalid vector gave no address error trap");
	a_level7_block: assert property (cpu_priority_level == 4'h7 |=>
		!irq_valid_q)
		else $error("interrupt passed at level seven");
	c_irq_win: cover property (irq_valid_q && irq_level_q == 3'h7);
	c_trap_take: cover property (trap_take_q);
	c_dev_reset: cover property (device_reset_q);
endmodule : interrupt_priority_trap_arbiter

// [irq_arbiter_map.svh]
`ifndef IRQ_ARBITER_MAP_SVH
`define IRQ_ARBITER_MAP_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFS_FLAG0 8'h00
`define OFS_FLAG1 8'h04
`define OFS_EN0 8'h08
`define OFS_EN1 8'h0C
`define OFS_CTRL 8'h10
`define OFS_STAT 8'h14
`define OFS_CAUSE 8'h18
`define OFS_PRIO_BASE 8'h20
`define OFS_PRIO_LAST 8'h38

// ****************************************************************
// Sources, vectors and levels
// ****************************************************************
`define NUM_SRC 54
`define NUM_PRIO_WORDS 7
`define FLAG1_BITS 22
`define RSV_MASK 54'h3F_E64F_C306_0000
`define VECTOR_OFFSET 6'h08
`define PRIO_MASK 4'h7
`define NUM_TRAPS 8
`define ADDR_ERR_TRAP 3'h4
`define RESET_PC 24'h00_0000

// ****************************************************************
// Reset cause bits
// ****************************************************************
`define CAUSE_WDT 0
`define CAUSE_BOR 1
`define CAUSE_UNINIT 2
`define CAUSE_ILLEGAL 3
`define CAUSE_LOCKOUT 4
`define NUM_CAUSES 5

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// [irq_arbiter_pkg.sv]
package irq_arbiter_pkg;
	typedef logic [53:0] src_vec_t;
	typedef logic [2:0] prio_t;
	typedef logic [3:0] level_t;
	typedef logic [5:0] num_t;
	typedef logic [7:0] trap_vec_t;
endpackage : irq_arbiter_pkg

// [core_level_model.sv]
`timescale 1ns/1ns

// ****************************************
// Processor core priority level
// ****************************************
module core_level_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [3:0] lvl_cmd,
	input wire logic lvl_load,
	input wire logic trap_take_q,
	input wire logic [3:0] trap_level_q,
	output logic [3:0] cpu_priority_level
);
	// A taken trap overrides a software level write in the same cycle.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cpu_priority_level <= 4'h0;
		end else if (trap_take_q) begin
			cpu_priority_level <= trap_level_q;
		end else if (lvl_load) begin
			cpu_priority_level <= lvl_cmd;
		end
	end
endmodule : core_level_model

// [interrupt_priority_trap_arbiter_test.sv]
`timescale 1ns/1ns
`include "irq_arbiter_map.svh"

module interrupt_priority_trap_arbiter_test;
	import irq_arbiter_pkg::*;
	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
	logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, in_service, lvl_load;
	logic irq_valid_q, trap_take_q, device_reset_q, nesting_disable_q;
	logic [7:0] s_axi_awaddr, s_axi_araddr, trap_req;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [53:0] irq_event;
	logic [6:0] ev;
	logic [3:0] lvl_cmd, cpu_priority_level, trap_level_q;
	logic [5:0] irq_num_q, irq_vector_q;
	logic [2:0] irq_level_q;
	logic [23:0] start_addr_q;
	int fail_count, n_tests;

	interrupt_priority_trap_arbiter u_dut (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .irq_event, .cpu_priority_level,
		.in_service, .trap_req, .instr_done(ev[5]), .vector_invalid(ev[6]),
		.watchdog_timeout(ev[0]), .brown_out_reset(ev[1]),
		.uninit_pointer_use(ev[2]), .illegal_opcode_fetch(ev[3]),
		.illegal_opcode_flushed(ev[4]), .irq_valid_q, .irq_num_q,
		.irq_vector_q, .irq_level_q, .trap_take_q, .trap_level_q,
		.device_reset_q, .start_addr_q, .nesting_disable_q
	);
	core_level_model u_core (
		.aclk, .aresetn, .lvl_cmd, .lvl_load, .trap_take_q, .trap_level_q,
		.cpu_priority_level
	);

	// ****************************************
	// Bus cycles and comparisons
	// ****************************************
	task chk_reg(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk_reg

	task chk_pin(input logic [23:0] g, input logic [23:0] e);
		n_tests++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk_pin

	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw_d, w_d;
		aw_d = 1'b0;
		w_d = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw_d && w_d)) begin
			@(posedge aclk);
			if (!aw_d && s_axi_awready === 1'b1) begin
				aw_d = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_d && s_axi_wready === 1'b1) begin
				w_d = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		while (s_axi_bvalid !== 1'b1) @(posedge aclk);
		s_axi_bready <= 1'b0;
		chk_pin(24'(s_axi_bresp), 24'(er));
	endtask : wr

	task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		chk_reg(s_axi_rdata, e);
		chk_pin(24'(s_axi_rresp), 24'(er));
	endtask : rd

	task idle(input int n);
		repeat (n) @(posedge aclk);
		#1;
	endtask : idle

	// The arbiter answers at most two edges after any cause, so three edges settle.
	task win(input logic v, input logic [5:0] n, input logic [2:0] l);
		idle(3);
		chk_pin(24'(irq_valid_q), 24'(v));
		if (v) begin
			chk_pin(24'(irq_num_q), 24'(n));
			chk_pin(24'(irq_vector_q), 24'(n + 6'h08));
			chk_pin(24'(irq_level_q), 24'(l));
		end
	endtask : win

	task pulse(input logic [6:0] e, input logic [7:0] t, input logic [53:0] q);
		@(posedge aclk);
		ev <= e;
		trap_req <= t;
		irq_event <= q;
		@(posedge aclk);
		ev <= 7'h00;
		trap_req <= 8'h00;
		irq_event <= 54'h0;
		#1;
	endtask : pulse

	task set_lvl(input logic [3:0] v);
		@(posedge aclk);
		lvl_cmd <= v;
		lvl_load <= 1'b1;
		@(posedge aclk);
		lvl_load <= 1'b0;
	endtask : set_lvl

	task report_and_stop;
		if (fail_count == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : report_and_stop

	// ****************************************
	// Sequence
	// ****************************************
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	initial begin
		repeat (5000) @(posedge aclk);
		fail_count++;
		report_and_stop();
	end

	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
		{s_axi_arvalid, s_axi_rready, lvl_load, in_service} = 4'h0;
		{s_axi_awaddr, s_axi_araddr, trap_req} = 24'h0;
		{s_axi_wdata, irq_event, ev, lvl_cmd} = '0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		idle(2);
		chk_pin(start_addr_q, 24'h00_0000);
		chk_pin(24'(device_reset_q), 24'h0);
		rd(`OFS_STAT, 32'h0, `RESP_OKAY);
		wr(`OFS_PRIO_BASE, 32'hFFFF_FFFF, `RESP_OKAY);
		rd(`OFS_PRIO_BASE, 32'h7777_7777, `RESP_OKAY);
		wr(`OFS_PRIO_BASE, 32'h0000_5050, `RESP_OKAY);
		pulse(7'h00, 8'h00, 54'h2_000C);
		rd(`OFS_FLAG0, 32'h0000_000C, `RESP_OKAY);
		win(1'b0, 6'h00, 3'h0);
		wr(`OFS_EN0, 32'hFFFF_FFFF, `RESP_OKAY);
		wr(`OFS_EN1, 32'h003F_FFFF, `RESP_OKAY);
		win(1'b1, 6'h03, 3'h5);
		pulse(7'h00, 8'h00, 54'h2);
		win(1'b1, 6'h01, 3'h5);
		wr(`OFS_PRIO_BASE + 8'h14, 32'h6, `RESP_OKAY);
		pulse(7'h00, 8'h00, 54'h100_0000_0000);
		win(1'b1, 6'h28, 3'h6);
		set_lvl(4'h5);
		win(1'b1, 6'h28, 3'h6);
		set_lvl(4'h6);
		win(1'b0, 6'h00, 3'h0);
		set_lvl(4'h7);
		win(1'b0, 6'h00, 3'h0);
		set_lvl(4'h8);
		win(1'b0, 6'h00, 3'h0);
		set_lvl(4'h0);
		wr(`OFS_CTRL, 32'h1, `RESP_OKAY);
		@(posedge aclk);
		in_service <= 1'b1;
		win(1'b0, 6'h00, 3'h0);
		chk_pin(24'(nesting_disable_q), 24'h1);
		@(posedge aclk);
		in_service <= 1'b0;
		win(1'b1, 6'h28, 3'h6);
		wr(`OFS_FLAG1, 32'h100, `RESP_OKAY);
		win(1'b1, 6'h01, 3'h5);
		rd(`OFS_STAT, 32'h41, `RESP_OKAY);
		rd(8'h40, 32'h0, `RESP_SLVERR);
		wr(8'h40, 32'h5, `RESP_SLVERR);
		wr(`OFS_FLAG0, 32'hA, `RESP_OKAY);
		win(1'b0, 6'h00, 3'h0);
		pulse(7'h00, 8'h00, 54'h2);
		pulse(7'h00, 8'h04, 54'h0);
		chk_pin(24'(trap_take_q), 24'h0);
		rd(`OFS_STAT, 32'h0000_0241, `RESP_OKAY);
		pulse(7'h20, 8'h00, 54'h0);
		chk_pin(24'(trap_take_q), 24'h1);
		chk_pin(24'(trap_level_q), 24'hA);
		win(1'b0, 6'h00, 3'h0);
		// Only this vector is corrupt; the rest point at reset-only handlers.
		pulse(7'h40, 8'h00, 54'h0);
		pulse(7'h20, 8'h00, 54'h0);
		chk_pin(24'(trap_level_q), 24'hC);
		set_lvl(4'h7);
		pulse(7'h00, 8'h01, 54'h0);
		pulse(7'h20, 8'h00, 54'h0);
		chk_pin(24'(trap_level_q), 24'h8);
		set_lvl(4'h0);
		win(1'b1, 6'h01, 3'h5);
		for (int i = 0; i < 4; i++) begin
			pulse(7'(1 << i), 8'h00, 54'h0);
			chk_pin(24'(device_reset_q), 24'h1);
		end
		rd(`OFS_CAUSE, 32'hF, `RESP_OKAY);
		wr(`OFS_CAUSE, 32'h1F, `RESP_OKAY);
		pulse(7'h18, 8'h00, 54'h0);
		chk_pin(24'(device_reset_q), 24'h0);
		pulse(7'h00, 8'h03, 54'h0);
		chk_pin(24'(device_reset_q), 24'h1);
		rd(`OFS_CAUSE, 32'h10, `RESP_OKAY);
		// A new event on source zero lands in the clearing cycle.
		fork
			wr(`OFS_FLAG0, 32'h1, `RESP_OKAY);
			begin
				@(posedge aclk);
				pulse(7'h00, 8'h00, 54'h1);
			end
		join
		rd(`OFS_FLAG0, 32'h7, `RESP_OKAY);
		report_and_stop();
	end
endmodule : interrupt_priority_trap_arbiter_test
